// *** common/sscl_pkg.sv ***
// package with constants shared by both ends of the serial switch latch link
package sscl_pkg;
   localparam int          SSCL_BITS      = 8;
   localparam logic [7:0]  SSCL_ZERO      = 8'h00;
   localparam int          SSCL_MSB       = 7;
   localparam logic [2:0]  SSCL_CNT_LAST  = 3'h7;
   localparam logic [2:0]  SSCL_CNT_ZERO  = 3'h0;
   // host divides clk by 2*SSCL_HALF_DIV to make the serial clock
   localparam logic [3:0]  SSCL_HALF_DIV  = 4'h5;
   localparam logic [3:0]  SSCL_DIV_ZERO  = 4'h0;
   localparam logic [3:0]  SSCL_DIV_ONE   = 4'h1;
   // most devices the host drives in one chain; larger counts clip to one
   localparam logic [3:0]  SSCL_CHAIN_MAX = 4'h4;
   localparam logic [5:0]  SSCL_WORD_ZERO = 6'h00;
   // avalon register offsets (byte addresses)
   localparam logic [3:0]  SSCL_REG_DATA  = 4'h0;
   localparam logic [3:0]  SSCL_REG_CTRL  = 4'h4;
   localparam logic [3:0]  SSCL_REG_STAT  = 4'h8;
   localparam logic [3:0]  SSCL_REG_RBACK = 4'hC;
   // control register fields
   localparam int          SSCL_CTRL_GO    = 0;
   localparam int          SSCL_CTRL_CLR   = 1;
   localparam int          SSCL_CTRL_CNT_L = 4;
   localparam logic [31:0] SSCL_BAD_READ  = 32'hDEADBEEF;

   typedef enum logic [2:0] {
      SSCL_IDLE  = 3'b000,
      SSCL_LOW   = 3'b001,
      SSCL_HIGH  = 3'b011,
      SSCL_LOAD  = 3'b010,
      SSCL_DONE  = 3'b110
   } sscl_state_type;
endpackage

// *** common/sscl_if.sv ***
// interface carrying the serial control link between host and device
`timescale 1ns/10ps
interface sscl_if;
   logic serial_clk;
   logic serial_din;
   logic serial_dout;
   logic latch_load_n;
   logic latch_clear;
   modport device (input serial_clk, input serial_din, output serial_dout,
                   input latch_load_n, input latch_clear);
   modport host   (output serial_clk, output serial_din, input serial_dout,
                   output latch_load_n, output latch_clear);
endinterface

// *** hdl/sscl_device.sv ***
// device end: shift register, transparent latch and switch enables
//
// Operation
// - sample data on rising serial clock, msb first
// - serial output updates on rising serial clock
// - serial output repeats input eight clocks later
// - latch bit n drives switch channel n
// - load low, clear low: latch follows shifter
// - load high, clear low: latch holds
// - controller keeps load high while shifting
// - clear high forces latch to zero
// - clear leaves shifter and serial output alone
// - load pulse after clear restores latch
// - shifter and latch reset to zero
// - chain shares clock, load and clear
// - plain shift stages may join the chain
`timescale 1ns/10ps
module sscl_device (
   // system
   input  wire logic                clk,
   input  wire logic                reset,
   // link
   sscl_if.device                   link,
   // switch enables
   output      logic [7:0]          switch_on
);
   import sscl_pkg::*;

   logic [2:0] clk_sync_q;
   logic [1:0] din_sync_q;
   logic [1:0] load_sync_q;
   logic [1:0] clr_sync_q;
   logic       rise;
   logic [7:0] shift_q;
   logic [7:0] latch_q;

   // two-stage synchronisers; third clock stage only for edge detect
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         clk_sync_q  <= 3'h0;
         din_sync_q  <= 2'h0;
         load_sync_q <= 2'h3;
         clr_sync_q  <= 2'h0;
      end else begin
         clk_sync_q  <= {clk_sync_q[1:0], link.serial_clk};
         din_sync_q  <= {din_sync_q[0], link.serial_din};
         load_sync_q <= {load_sync_q[0], link.latch_load_n};
         clr_sync_q  <= {clr_sync_q[0], link.latch_clear};
      end
   end

   assign rise = clk_sync_q[1] & ~clk_sync_q[2];

   // shifter, msb enters first and moves up
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         shift_q <= SSCL_ZERO;
      end else if (rise) begin
         shift_q <= {shift_q[SSCL_MSB-1:0], din_sync_q[1]};
      end
   end

   // serial output is the last stage of the eight-bit shifter, so a chain adds eight per device
   assign link.serial_dout = shift_q[SSCL_MSB];

   // latch with clear priority
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         latch_q <= SSCL_ZERO;
      end else if (clr_sync_q[1]) begin
         latch_q <= SSCL_ZERO;
      end else if (!load_sync_q[1]) begin
         latch_q <= shift_q;
      end
   end

   // bit n drives channel n; high closes the switch
   assign switch_on = latch_q;
endmodule

// *** hdl/sscl_host.sv ***
// host end: avalon registers, serial clock divider and frame sequencer
`timescale 1ns/10ps
module sscl_host (
   // system
   input  wire logic                clk,
   input  wire logic                reset,
   // avalon-mm slave
   input  wire logic [3:0]          avs_address,
   input  wire logic                avs_read,
   input  wire logic                avs_write,
   input  wire logic [31:0]         avs_writedata,
   output      logic [31:0]         avs_readdata,
   output      logic                avs_waitrequest,
   // link
   sscl_if.host                     link
);
   import sscl_pkg::*;

   logic [7:0]        data_q [0:3];
   logic [3:0]        count_q;
   logic              clear_q;
   logic              busy_q;
   sscl_state_type    state_q;
   logic [3:0]        div_q;
   logic [2:0]        bit_q;
   logic [1:0]        word_q;
   logic              sclk_q;
   logic              sdo_q;
   logic              load_n_q;
   logic [7:0]        rback_q;
   logic [1:0]        dout_sync_q;
   logic [31:0]       rdata_q;
   logic              wait_q;
   logic              go;
   logic              tick;

   function automatic logic [3:0] sscl_clip(input logic [3:0] n);
      sscl_clip = (n == SSCL_DIV_ZERO || n > SSCL_CHAIN_MAX) ? SSCL_DIV_ONE : n;
   endfunction

   assign go   = avs_write && !wait_q && avs_address == SSCL_REG_CTRL
                 && avs_writedata[SSCL_CTRL_GO] && !busy_q;
   assign tick = (div_q == SSCL_HALF_DIV - SSCL_DIV_ONE);

   // avalon: one wait cycle, answer on the second edge
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         wait_q  <= 1'b1;
         rdata_q <= 32'h0;
      end else begin
         wait_q <= ~((avs_read | avs_write) & wait_q);
         if (avs_read && wait_q) begin
            case (avs_address)
               SSCL_REG_DATA:  rdata_q <= {data_q[3], data_q[2], data_q[1], data_q[0]};
               SSCL_REG_CTRL:  rdata_q <= {24'h0, count_q, 2'h0, clear_q, 1'b0};
               SSCL_REG_STAT:  rdata_q <= {31'h0, busy_q};
               SSCL_REG_RBACK: rdata_q <= {24'h0, rback_q};
               default:        rdata_q <= SSCL_BAD_READ;
            endcase
         end
      end
   end

   assign avs_waitrequest = wait_q;
   assign avs_readdata    = rdata_q;

   // register writes
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         for (int i = 0; i < 4; i++) begin
            data_q[i] <= SSCL_ZERO;
         end
         count_q <= SSCL_DIV_ONE;
         clear_q <= 1'b0;
      end else if (avs_write && !wait_q) begin
         if (avs_address == SSCL_REG_DATA && !busy_q) begin
            for (int i = 0; i < 4; i++) begin
               data_q[i] <= avs_writedata[i*8 +: 8];
            end
         end
         if (avs_address == SSCL_REG_CTRL) begin
            clear_q <= avs_writedata[SSCL_CTRL_CLR];
            count_q <= sscl_clip(avs_writedata[SSCL_CTRL_CNT_L +: 4]);
         end
      end
   end

   assign link.latch_clear = clear_q;

   // frame sequencer: load held high while shifting, then low pulse
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_q  <= SSCL_IDLE;
         busy_q   <= 1'b0;
         div_q    <= SSCL_DIV_ZERO;
         bit_q    <= SSCL_CNT_ZERO;
         word_q   <= 2'h0;
         sclk_q   <= 1'b0;
         sdo_q    <= 1'b0;
         load_n_q <= 1'b1;
         rback_q  <= SSCL_ZERO;
      end else begin
         div_q <= (tick || state_q == SSCL_IDLE) ? SSCL_DIV_ZERO : div_q + SSCL_DIV_ONE;
         case (state_q)
            SSCL_IDLE: begin
               if (go) begin
                  busy_q  <= 1'b1;
                  bit_q   <= SSCL_CNT_ZERO;
                  // farthest device first, msb first
                  word_q  <= 2'(count_q - SSCL_DIV_ONE);
                  sdo_q   <= data_q[2'(count_q - SSCL_DIV_ONE)][SSCL_MSB];
                  state_q <= SSCL_LOW;
               end
            end
            SSCL_LOW: begin
               if (tick) begin
                  sclk_q  <= 1'b1;
                  rback_q <= {rback_q[SSCL_MSB-1:0], dout_sync_q[1]};
                  state_q <= SSCL_HIGH;
               end
            end
            SSCL_HIGH: begin
               if (tick) begin
                  sclk_q <= 1'b0;
                  bit_q  <= bit_q + 3'h1;
                  if (bit_q == SSCL_CNT_LAST) begin
                     if (word_q == 2'h0) begin
                        state_q <= SSCL_LOAD;
                        load_n_q <= 1'b0;
                     end else begin
                        word_q  <= word_q - 2'h1;
                        sdo_q   <= data_q[word_q - 2'h1][SSCL_MSB];
                        state_q <= SSCL_LOW;
                     end
                  end else begin
                     sdo_q   <= data_q[word_q][3'(SSCL_MSB) - bit_q - 3'h1];
                     state_q <= SSCL_LOW;
                  end
               end
            end
            SSCL_LOAD: begin
               if (tick) begin
                  load_n_q <= 1'b1;
                  state_q  <= SSCL_DONE;
               end
            end
            SSCL_DONE: begin
               busy_q  <= 1'b0;
               state_q <= SSCL_IDLE;
            end
            default: state_q <= SSCL_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         dout_sync_q <= 2'h0;
      end else begin
         dout_sync_q <= {dout_sync_q[0], link.serial_dout};
      end
   end

   assign link.serial_clk   = sclk_q;
   assign link.serial_din   = sdo_q;
   assign link.latch_load_n = load_n_q;
endmodule

// *** testbench/sscl_checker.sv ***
// checker of the link between host and device ends
`timescale 1ns/10ps
module sscl_checker (
   // system
   input wire logic       clk,
   input wire logic       reset,
   // link
   input wire logic       serial_clk,
   input wire logic       serial_din,
   input wire logic       serial_dout,
   input wire logic       latch_load_n,
   input wire logic       latch_clear,
   // switches
   input wire logic [7:0] switch_on
);
   logic       sclk_q;
   logic [7:0] hist_q;
   default clocking @(posedge clk);
   endclocking
   default disable iff (reset);
   // model of the din history, one step per serial clock rise
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         sclk_q <= 1'b0;
         hist_q <= 8'h00;
      end else begin
         sclk_q <= serial_clk;
         if (serial_clk && !sclk_q) begin
            hist_q <= {hist_q[6:0], serial_din};
         end
      end
   end
   clear_zero_a: assert property (latch_clear [*5] |-> switch_on == 8'h00)
      else $error("switches not open under clear");
   hold_latch_a: assert property ((latch_load_n && !latch_clear) [*6] |-> $stable(switch_on))
      else $error("switches moved while latch held");
   load_follow_a: assert property ($rose(latch_load_n) && !latch_clear && !$past(latch_clear, 6)
      |=> switch_on == hist_q[7:0]) else $error("latch differs from shifted bits");
   dout_chain_a: assert property ($fell(serial_clk) |-> serial_dout == hist_q[7])
      else $error("serial output not eight clocks late");
   dout_quiet_a: assert property (!serial_clk [*6] |=> $stable(serial_dout))
      else $error("serial output moved without clock rise");
   clear_dout_a: assert property ($rose(latch_clear) |-> $stable(serial_dout) [*4])
      else $error("clear disturbed serial output");
   din_setup_a: assert property ($rose(serial_clk) |-> $stable(serial_din) [*4])
      else $error("data moved around clock rise");
   load_idle_a: assert property (!latch_load_n |-> !serial_clk)
      else $error("load low while shifting");
   reset_open_a: assert property ($fell(reset) |-> switch_on == 8'h00)
      else $error("switches not open after reset");
endmodule

// *** testbench/tb_serial_switch_control_latch.sv ***
// bench driving the host over avalon and watching the device switches
`timescale 1ns/10ps
module tb_serial_switch_control_latch;
   import sscl_pkg::*;
   typedef struct packed {
      logic [31:0] data;
      logic [7:0]  ctrl;
      logic [7:0]  exp;
   } sscl_row_type;
   logic         clk;
   logic         reset;
   logic [3:0]   avs_address;
   logic         avs_read;
   logic         avs_write;
   logic [31:0]  avs_writedata;
   logic [31:0]  avs_readdata;
   logic         avs_waitrequest;
   logic [7:0]   switch_on;
   logic [31:0]  rd_q;
   int           err_count = 0;
   int           cmp_count = 0;
   int           cyc = 0;
   sscl_row_type rows [5] = '{'{32'h000000A5, 8'h11, 8'hA5}, '{32'h0000C35A, 8'h21, 8'h5A},
      '{32'h11223380, 8'h41, 8'h80}, '{32'h00000001, 8'h01, 8'h01},
      '{32'h0000003C, 8'h51, 8'h3C}};
   sscl_if link ();
   sscl_host i_sscl_host (.clk(clk), .reset(reset), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .link(link));
   sscl_device i_sscl_device (.clk(clk), .reset(reset), .link(link), .switch_on(switch_on));
   sscl_checker i_sscl_checker (.clk(clk), .reset(reset), .serial_clk(link.serial_clk),
      .serial_din(link.serial_din), .serial_dout(link.serial_dout),
      .latch_load_n(link.latch_load_n), .latch_clear(link.latch_clear),
      .switch_on(switch_on));
   task automatic report_and_stop;
      $display("errors %0d checks %0d", err_count, cmp_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   // one avalon transfer, held until waitrequest is seen low
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= d;
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      rd_q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task automatic frame(input logic [31:0] d, input logic [31:0] c);
      bus(1'b1, SSCL_REG_DATA, d);
      bus(1'b1, SSCL_REG_CTRL, c);
      rd_q = 32'h1;
      while (rd_q[0] !== 1'b0) bus(1'b0, SSCL_REG_STAT, 32'h0);
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         err_count++;
         report_and_stop();
      end
   end
   initial begin
      reset = 1'b1;
      avs_address = 4'h0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      repeat (12) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      check({24'h0, switch_on}, 32'h0);
      bus(1'b0, 4'h2, 32'h0);
      check(rd_q, SSCL_BAD_READ);
      foreach (rows[i]) begin
         frame(rows[i].data, {24'h0, rows[i].ctrl});
         check({24'h0, switch_on}, {24'h0, rows[i].exp});
         check({30'h0, link.latch_load_n, link.serial_clk}, 32'h2);
      end
      bus(1'b1, SSCL_REG_CTRL, 32'h2);
      repeat (6) @(posedge clk);
      check({24'h0, switch_on}, 32'h0);
      frame(32'h0000003C, 32'h13);
      check({24'h0, switch_on}, 32'h0);
      bus(1'b1, SSCL_REG_CTRL, 32'h10);
      repeat (6) @(posedge clk);
      check({24'h0, switch_on}, 32'h0);
      frame(32'h0000003C, 32'h11);
      check({24'h0, switch_on}, 32'h3C);
      bus(1'b0, SSCL_REG_RBACK, 32'h0);
      check(rd_q, 32'h3C);
      @(posedge clk);
      reset <= 1'b1;
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      check({24'h0, switch_on}, 32'h0);
      bus(1'b0, SSCL_REG_CTRL, 32'h0);
      check(rd_q, 32'h10);
      frame(32'h000000A5, 32'h11);
      check({24'h0, switch_on}, 32'hA5);
      bus(1'b0, SSCL_REG_RBACK, 32'h0);
      check(rd_q, 32'h0);
      report_and_stop();
   end
endmodule
